// ---- hw/word_ctrl_pkg.sv ----
`default_nettype none
package word_ctrl_pkg;

  // Serial word layout
  localparam int WORD_W   = 16;
  localparam int DAC_W    = 14;
  localparam int DAC_LSB  = 2;
  localparam int CODE_W   = 4;
  localparam logic [3:0] BIT_LAST = 4'hf;

  // Control code {word_ctrl_bit_hi, word_ctrl_bit_lo, fc_hi, fc_lo}
  localparam logic [3:0] CODE_DLY_FC   = 4'h1;
  localparam logic [3:0] CODE_ADV_FC   = 4'h2;
  localparam logic [3:0] CODE_DLY_WORD = 4'h4;
  localparam logic [3:0] CODE_ADV_WORD = 4'h8;
  localparam logic [1:0] PAIR_SEC      = 2'h3;

  // APB register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PHASE  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_SEC    = 8'h0c;

  // Field positions and reset values
  localparam int CTRL_RUN_BIT  = 0;
  localparam int STAT_SEC_BIT  = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam logic       CTRL_RESET  = 1'h0;
  localparam logic [7:0] PHASE_RESET = 8'h00;

  // Clock
  localparam int CLK_PERIOD_NS = 4;

  typedef enum logic {LINK_IDLE, LINK_SHIFT} link_state_e;

endpackage
`default_nettype wire

// ---- hw/primary_word_control_decode.sv ----
// Operation
// - Each primary frame: take DAC bits, send ADC word
// - Undefined control codes change nothing
// - Code 0001 delays next sample by step
// - Code 0010 advances next sample by step
// - Code 0100 delays next sample by step
// - Code 1000 advances next sample by step
// - Both function inputs high: secondary frame
// - Both word control bits high: secondary frame
// - Secondary frame half a period after primary
// - Adjustment applies at next frame only
// - Primary falling edges bound one conversion period
// - Output on rising, input on falling shift edge
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module primary_word_control_decode
  import word_ctrl_pkg::*;
#(
  parameter int SAMPLE_PERIOD = 2048,
  parameter int CNT_W         = 16,
  parameter int PHASE_W       = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [WORD_W-1:0] adc_data,
  output var  logic              sample_pulse,
  output var  logic [DAC_W-1:0]  dac_data,
  output var  logic              dac_valid,
  input  wire logic              func_ctrl_in_hi,
  input  wire logic              func_ctrl_in_lo,
  input  wire logic              sclk,
  output var  logic              frame_sync_n,
  output var  logic              dout,
  output var  logic              dout_oe_n,
  input  wire logic              din
);

  localparam int ADJ_W = CNT_W + 2;
  localparam logic [CNT_W-1:0] PERIOD_M1 = CNT_W'(SAMPLE_PERIOD - 1);
  localparam logic [CNT_W-1:0] HALF_PT   = CNT_W'(SAMPLE_PERIOD / 2);
  localparam logic [CNT_W-1:0] MIN_LOAD  = CNT_W'(SAMPLE_PERIOD / 2 + 1);

  // Master clock domain state
  logic                    run_reg;
  logic [PHASE_W-1:0]      phase_step_reg;
  logic                    sec_valid_reg;
  logic [WORD_W-1:0]       sec_word_reg;
  logic [CNT_W-1:0]        cnt_reg;
  logic signed [ADJ_W-1:0] adj_reg;
  logic                    sec_pend_reg;
  logic                    prim_tgl_reg;
  logic                    sec_tgl_reg;
  logic [WORD_W-1:0]       tx_word_reg;
  logic [2:0]              cs1_reg;
  logic [2:0]              cs2_reg;
  logic [2:0]              cs3_reg;
  logic [2:0]              cstab_reg;
  logic                    rx_seen_reg;
  logic [31:0]             prdata_reg;
  logic                    pready_reg;
  logic                    pslverr_reg;
  logic                    sample_pulse_reg;
  logic [DAC_W-1:0]        dac_data_reg;
  logic                    dac_valid_reg;

  // Link clock domain state
  link_state_e             link_state_reg;
  logic [1:0]              ls1_reg;
  logic [1:0]              ls2_reg;
  logic [1:0]              ls3_reg;
  logic [1:0]              lstab_reg;
  logic [1:0]              lseen_reg;
  logic [WORD_W-1:0]       tx_sh_reg;
  logic [3:0]              tx_cnt_reg;
  logic                    kind_reg;
  logic                    frame_sync_n_reg;
  logic                    dout_reg;
  logic                    dout_oe_n_reg;
  logic [WORD_W-1:0]       rx_sh_reg;
  logic [3:0]              rx_cnt_reg;
  logic [WORD_W-1:0]       rx_hold_reg;
  logic                    rx_kind_reg;
  logic                    rx_tgl_reg;

  // APB decode
  wire apb_setup  = psel & ~penable;
  wire apb_write  = psel & penable & pready_reg & pwrite;
  wire hit_ctrl   = (paddr == OFF_CTRL);
  wire hit_phase  = (paddr == OFF_PHASE);
  wire hit_status = (paddr == OFF_STATUS);
  wire hit_sec    = (paddr == OFF_SEC);
  wire hit_any    = hit_ctrl | hit_phase | hit_status | hit_sec;
  wire [31:0] rd_data =
    hit_ctrl   ? {31'h0, run_reg} :
    hit_phase  ? {{(32-PHASE_W){1'b0}}, phase_step_reg} :
    hit_status ? {30'h0, sec_pend_reg, sec_valid_reg} :
    hit_sec    ? {16'h0, sec_word_reg} : 32'h0;
  wire sec_clear = apb_write & hit_status & pwdata[STAT_SEC_BIT];

  // Pin and toggle synchroniser: a bit moves once stages two and three agree
  wire [2:0] cdiff = cs2_reg ^ cs3_reg;
  wire [2:0] cstab_next = (cs2_reg & ~cdiff) | (cstab_reg & cdiff);
  wire [1:0] fc_stable = cstab_reg[1:0];
  wire       rx_evt    = cstab_reg[2] ^ rx_seen_reg;
  wire       rx_prim   = rx_evt & ~rx_kind_reg;
  wire       rx_sec    = rx_evt & rx_kind_reg;

  // Control code of the primary word just received
  wire [CODE_W-1:0] code = {rx_hold_reg[1:0], fc_stable};
  wire is_dly = (code == CODE_DLY_FC) | (code == CODE_DLY_WORD);
  wire is_adv = (code == CODE_ADV_FC) | (code == CODE_ADV_WORD);
  wire is_sec = (code[1:0] == PAIR_SEC) | (code[3:2] == PAIR_SEC);

  wire signed [ADJ_W-1:0] step_ext =
    signed'({{(ADJ_W-PHASE_W){phase_step_reg[PHASE_W-1]}}, phase_step_reg});

  // delay or advance select; else hold
  wire signed [ADJ_W-1:0] adj_sel =
    is_dly ? step_ext : (is_adv ? -step_ext : adj_reg);

  // Reload, clamped so the half-period point always exists
  wire signed [ADJ_W-1:0] load_raw = signed'({2'b00, PERIOD_M1}) + adj_reg;
  wire load_low = load_raw < signed'({2'b00, MIN_LOAD});
  wire [CNT_W-1:0] load_val = load_low ? MIN_LOAD : load_raw[CNT_W-1:0];

  wire instant  = run_reg & (cnt_reg == {CNT_W{1'b0}});
  wire sec_fire = run_reg & (cnt_reg == HALF_PT) & sec_pend_reg;

  // APB slave: no wait states, pready from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg     <= 1'b0;
      pslverr_reg    <= 1'b0;
      prdata_reg     <= 32'h0;
      run_reg        <= CTRL_RESET;
      phase_step_reg <= PHASE_RESET;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup & ~hit_any;
      prdata_reg  <= apb_setup ? rd_data : 32'h0;
      if (apb_write & hit_ctrl) begin
        run_reg <= pwdata[CTRL_RUN_BIT];
      end
      if (apb_write & hit_phase) begin
        phase_step_reg <= pwdata[PHASE_W-1:0];
      end
    end
  end

  // Synchronisers for function pins and the receive toggle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs1_reg     <= 3'h0;
      cs2_reg     <= 3'h0;
      cs3_reg     <= 3'h0;
      cstab_reg   <= 3'h0;
      rx_seen_reg <= 1'b0;
    end else begin
      cs1_reg     <= {rx_tgl_reg, func_ctrl_in_hi, func_ctrl_in_lo};
      cs2_reg     <= cs1_reg;
      cs3_reg     <= cs2_reg;
      cstab_reg   <= cstab_next;
      rx_seen_reg <= cstab_reg[2];
    end
  end

  // conversion period counter; adjustment used once at reload
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg          <= {CNT_W{1'b0}};
      adj_reg          <= '0;
      prim_tgl_reg     <= 1'b0;
      tx_word_reg      <= '0;
      sample_pulse_reg <= 1'b0;
    end else begin
      sample_pulse_reg <= instant;
      if (!run_reg) begin
        cnt_reg <= PERIOD_M1;
      end else if (instant) begin
        cnt_reg <= load_val;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
      if (instant) begin
        tx_word_reg  <= adc_data;
        prim_tgl_reg <= ~prim_tgl_reg;
      end
      // A new request wins over the clear at reload
      if (rx_prim) begin
        adj_reg <= adj_sel;
      end else if (instant) begin
        adj_reg <= '0;
      end
    end
  end

  // secondary request; fired at half period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_pend_reg <= 1'b0;
      sec_tgl_reg  <= 1'b0;
    end else begin
      if (rx_prim & is_sec) begin
        sec_pend_reg <= 1'b1;
      end else if (sec_fire) begin
        sec_pend_reg <= 1'b0;
      end
      if (sec_fire) begin
        sec_tgl_reg <= ~sec_tgl_reg;
      end
    end
  end

  // received data out; secondary word kept, sticky flag set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_data_reg  <= '0;
      dac_valid_reg <= 1'b0;
      sec_word_reg  <= '0;
      sec_valid_reg <= 1'b0;
    end else begin
      dac_valid_reg <= rx_prim;
      if (rx_prim) begin
        dac_data_reg <= rx_hold_reg[WORD_W-1:DAC_LSB];
      end
      if (rx_sec) begin
        sec_word_reg <= rx_hold_reg;
      end
      if (rx_sec) begin
        sec_valid_reg <= 1'b1;
      end else if (sec_clear) begin
        sec_valid_reg <= 1'b0;
      end
    end
  end

  // Link side request decode
  wire [1:0] ldiff      = ls2_reg ^ ls3_reg;
  wire [1:0] lstab_next = (ls2_reg & ~ldiff) | (lstab_reg & ldiff);
  wire [1:0] lpend      = lstab_reg ^ lseen_reg;
  wire       start_prim = (link_state_reg == LINK_IDLE) & lpend[0];
  wire       start_sec  = (link_state_reg == LINK_IDLE) & ~lpend[0] & lpend[1];
  // Words read across domains are held still until the next request
  wire [WORD_W-1:0] start_word = start_prim ? tx_word_reg : {WORD_W{1'b0}};

  // Request synchronisers on the shift clock
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      ls1_reg   <= 2'h0;
      ls2_reg   <= 2'h0;
      ls3_reg   <= 2'h0;
      lstab_reg <= 2'h0;
      lseen_reg <= 2'h0;
    end else begin
      ls1_reg   <= {sec_tgl_reg, prim_tgl_reg};
      ls2_reg   <= ls1_reg;
      ls3_reg   <= ls2_reg;
      lstab_reg <= lstab_next;
      lseen_reg <= lseen_reg ^ {start_sec, start_prim};
    end
  end

  // frame sync pulse and output bits change on the rising edge
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      link_state_reg   <= LINK_IDLE;
      frame_sync_n_reg <= 1'b1;
      dout_reg         <= 1'b0;
      dout_oe_n_reg    <= 1'b1;
      tx_sh_reg        <= '0;
      tx_cnt_reg       <= 4'h0;
      kind_reg         <= 1'b0;
    end else begin
      case (link_state_reg)
        LINK_IDLE: begin
          if (start_prim | start_sec) begin
            link_state_reg   <= LINK_SHIFT;
            frame_sync_n_reg <= 1'b0;
            dout_oe_n_reg    <= 1'b0;
            dout_reg         <= start_word[WORD_W-1];
            tx_sh_reg        <= {start_word[WORD_W-2:0], 1'b0};
            tx_cnt_reg       <= BIT_LAST;
            kind_reg         <= start_sec;
          end
        end
        LINK_SHIFT: begin
          frame_sync_n_reg <= 1'b1;
          if (tx_cnt_reg == 4'h0) begin
            link_state_reg <= LINK_IDLE;
            dout_reg       <= 1'b0;
            dout_oe_n_reg  <= 1'b1;
          end else begin
            dout_reg   <= tx_sh_reg[WORD_W-1];
            tx_sh_reg  <= {tx_sh_reg[WORD_W-2:0], 1'b0};
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
          end
        end
        default: begin
          link_state_reg <= LINK_IDLE;
        end
      endcase
    end
  end

  // input bits sampled on the falling edge, 16 per frame
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_reg   <= '0;
      rx_cnt_reg  <= 4'h0;
      rx_hold_reg <= '0;
      rx_kind_reg <= 1'b0;
      rx_tgl_reg  <= 1'b0;
    end else if (!frame_sync_n_reg) begin
      rx_sh_reg  <= {rx_sh_reg[WORD_W-2:0], din};
      rx_cnt_reg <= 4'h1;
    end else if (rx_cnt_reg != 4'h0) begin
      rx_sh_reg  <= {rx_sh_reg[WORD_W-2:0], din};
      rx_cnt_reg <= rx_cnt_reg + 1'b1;
      if (rx_cnt_reg == BIT_LAST) begin
        rx_hold_reg <= {rx_sh_reg[WORD_W-2:0], din};
        rx_kind_reg <= kind_reg;
        rx_tgl_reg  <= ~rx_tgl_reg;
        rx_cnt_reg  <= 4'h0;
      end
    end
  end

  // Outputs
  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign sample_pulse = sample_pulse_reg;
  assign dac_data     = dac_data_reg;
  assign dac_valid    = dac_valid_reg;
  assign frame_sync_n = frame_sync_n_reg;
  assign dout         = dout_reg;
  assign dout_oe_n    = dout_oe_n_reg;

  // Assertions
  property p_delay;
    @(posedge clk) disable iff (!rst_n)
      rx_prim && is_dly |=> adj_reg == $past(step_ext);
  endproperty
  a_delay: assert property (p_delay)
    else $error("delay not taken");

  property p_advance;
    @(posedge clk) disable iff (!rst_n)
      rx_prim && is_adv |=> adj_reg == -$past(step_ext);
  endproperty
  a_advance: assert property (p_advance)
    else $error("advance wrong");

  property p_word_delay;
    @(posedge clk) disable iff (!rst_n)
      rx_prim && code == CODE_DLY_WORD |=> adj_reg == $past(step_ext);
  endproperty
  a_word_delay: assert property (p_word_delay)
    else $error("word delay not taken");

  property p_word_adv;
    @(posedge clk) disable iff (!rst_n)
      rx_prim && code == CODE_ADV_WORD |=> adj_reg == -$past(step_ext);
  endproperty
  a_word_adv: assert property (p_word_adv)
    else $error("word advance wrong");

  property p_ignore;
    @(posedge clk) disable iff (!rst_n)
      rx_prim && !is_dly && !is_adv && !is_sec && !instant
        |=> $stable(adj_reg);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("bad code acted");

  property p_sec_req;
    @(posedge clk) disable iff (!rst_n)
      rx_prim && (fc_stable == PAIR_SEC) |=> sec_pend_reg;
  endproperty
  a_sec_req: assert property (p_sec_req)
    else $error("no sec fc");

  property p_sec_bits;
    @(posedge clk) disable iff (!rst_n)
      rx_prim && (rx_hold_reg[1:0] == PAIR_SEC) |=> sec_pend_reg;
  endproperty
  a_sec_bits: assert property (p_sec_bits)
    else $error("no sec bits");

  property p_sec_half;
    @(posedge clk) disable iff (!rst_n)
      $changed(sec_tgl_reg) |-> $past(cnt_reg) == HALF_PT;
  endproperty
  a_sec_half: assert property (p_sec_half)
    else $error("sec off half");

  property p_adj_once;
    @(posedge clk) disable iff (!rst_n)
      instant && !rx_prim |=> adj_reg == 0 ##0 cnt_reg == $past(load_val);
  endproperty
  a_adj_once: assert property (p_adj_once)
    else $error("adjust misuse");

  property p_dac_out;
    @(posedge clk) disable iff (!rst_n)
      rx_prim |=> dac_valid_reg &&
        dac_data_reg == $past(rx_hold_reg[WORD_W-1:DAC_LSB]);
  endproperty
  a_dac_out: assert property (p_dac_out)
    else $error("dac data lost");

  property p_fs_pulse;
    @(posedge sclk) disable iff (!rst_n)
      $fell(frame_sync_n_reg) |=> frame_sync_n_reg && !dout_oe_n_reg;
  endproperty
  a_fs_pulse: assert property (p_fs_pulse)
    else $error("fs pulse");

  c_delay:  cover property (@(posedge clk) disable iff (!rst_n)
    rx_prim && is_dly);
  c_adv:    cover property (@(posedge clk) disable iff (!rst_n)
    rx_prim && is_adv);
  c_sec:    cover property (@(posedge clk) disable iff (!rst_n) sec_fire);
  c_secrx:  cover property (@(posedge clk) disable iff (!rst_n) rx_sec);

endmodule
`default_nettype wire

// ---- testbench/host_serial_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_serial_model (
  input  wire logic        sclk,
  input  wire logic        frame_sync_n,
  input  wire logic        dout,
  input  wire logic [15:0] tx_word,
  output var  logic        din,
  output var  logic [15:0] rx_word,
  output var  logic [31:0] rx_cnt
);
  logic [4:0]  left_reg = 5'h00;
  logic [15:0] shift_reg = 16'h0000;
  logic        last_reg = 1'b0;
  logic [4:0]  idx;
  logic        active;

  // Bits still owed in this frame
  // one word per frame
  always @(posedge sclk) begin
    if (!frame_sync_n) begin
      left_reg <= 5'h0f;
    end else if (left_reg != 5'h00) begin
      left_reg <= left_reg - 5'h01;
    end
  end

  // Released line shows the inverse of the last bit, never a stale level
  // host drives on rise
  assign active = !frame_sync_n || (left_reg != 5'h00);
  assign idx    = !frame_sync_n ? 5'h0f : left_reg - 5'h01;
  assign din    = active ? tx_word[idx[3:0]] : ~last_reg;

  // Capture the device word, MSB first
  // host samples on fall
  initial rx_cnt = 32'h0;
  always @(negedge sclk) begin
    if (active) begin
      last_reg  <= din;
      shift_reg <= {shift_reg[14:0], dout};
      if (idx == 5'h00) begin
        rx_word <= {shift_reg[14:0], dout};
        rx_cnt  <= rx_cnt + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/primary_word_control_decode_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module primary_word_control_decode_tb;
  import word_ctrl_pkg::*;
  localparam int SP    = 256;
  localparam int LIMIT = 30000;
  typedef struct packed {
    logic [3:0]        code;
    logic [7:0]        step;
    logic signed [7:0] delta;
    logic              sec;
  } row_s;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } reg_s;

  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        sample_pulse, dac_valid, fc_hi, fc_lo, sclk;
  logic        frame_sync_n, dout, dout_oe_n, din, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, rx_cnt;
  logic [15:0] adc_data, tx_word, rx_word;
  logic [13:0] dac_data;
  realtime     fall_t[$], pu_t[$], t1, t2;
  int          num_errors, n_tests, cyc, p, nfs, n0;

  // Ordinary cases: code {bit_hi,bit_lo,fc_hi,fc_lo}, step, period change
  row_s rows [15] = '{
    '{4'h0, 8'h05, 8'sh00, 1'b0},
    '{4'h1, 8'h05, 8'sh05, 1'b0},
    '{4'h2, 8'h05, -8'sh05, 1'b0},
    '{4'h4, 8'h05, 8'sh05, 1'b0},
    '{4'h8, 8'h05, -8'sh05, 1'b0},
    '{4'h4, 8'hfd, -8'sh03, 1'b0},
    '{4'h8, 8'hfd, 8'sh03, 1'b0},
    '{4'h1, 8'hfd, -8'sh03, 1'b0},
    '{4'h3, 8'h05, 8'sh00, 1'b1},
    '{4'hc, 8'h05, 8'sh00, 1'b1},
    '{4'h5, 8'h05, 8'sh00, 1'b0},
    '{4'h6, 8'h05, 8'sh00, 1'b0},
    '{4'h9, 8'h05, 8'sh00, 1'b0},
    '{4'ha, 8'h05, 8'sh00, 1'b0},
    '{4'hf, 8'h05, 8'sh00, 1'b1}
  };
  // Register map: reset values, read-only, width, unmapped
  reg_s regs [8] = '{
    '{1'b0, OFF_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFF_PHASE, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFF_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b1, OFF_SEC, 32'hffff, 32'h0, 1'b0},
    '{1'b0, OFF_SEC, 32'h0, 32'h0, 1'b0},
    '{1'b1, OFF_PHASE, 32'h1a5, 32'h0, 1'b0},
    '{1'b0, OFF_PHASE, 32'h0, 32'ha5, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1}
  };

  primary_word_control_decode #(.SAMPLE_PERIOD(SP)) i_dut (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_data(adc_data), .sample_pulse(sample_pulse),
    .dac_data(dac_data), .dac_valid(dac_valid),
    .func_ctrl_in_hi(fc_hi), .func_ctrl_in_lo(fc_lo), .sclk(sclk),
    .frame_sync_n(frame_sync_n), .dout(dout), .dout_oe_n(dout_oe_n),
    .din(din)
  );
  host_serial_model i_host (
    .sclk(sclk), .frame_sync_n(frame_sync_n), .dout(dout),
    .tx_word(tx_word), .din(din), .rx_word(rx_word), .rx_cnt(rx_cnt)
  );

  // Clocks, phase unrelated
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    sclk = 1'b0;
    #5;
    forever #6 sclk = ~sclk;
  end

  // Timestamps of sampling pulses and frame starts
  always @(posedge clk) if (sample_pulse === 1'b1) pu_t.push_back($realtime);
  always @(negedge frame_sync_n)
    if (rst_n === 1'b1) fall_t.push_back($realtime);

  // A hang ends the run through the same report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_dv();
    do begin
      @(posedge clk);
      #1;
    end while (dac_valid !== 1'b1);
  endtask

  function automatic logic [31:0] gap(input int k);
    return 32'(int'((pu_t[k+1] - pu_t[k]) / CLK_PERIOD_NS));
  endfunction

  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; adc_data = 16'h0000;
    tx_word = 16'h0000; fc_hi = 1'b0; fc_lo = 1'b0;
    num_errors = 0; n_tests = 0; cyc = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[i]) begin
      apb(regs[i].w, regs[i].a, regs[i].d, rd, er);
      chk(rd, regs[i].q);
      chk(32'(er), 32'(regs[i].e));
    end
    apb(1'b1, OFF_CTRL, 32'h1, rd, er);
    // Code goes in the next frame; neutral word afterwards
    foreach (rows[i]) begin
      wait_dv();
      apb(1'b1, OFF_PHASE, 32'(rows[i].step), rd, er);
      adc_data <= 16'h1234 + 16'(i);
      tx_word  <= {14'h1a5c + 14'(i), rows[i].code[3:2]};
      {fc_hi, fc_lo} <= rows[i].code[1:0];
      wait_dv();
      p = pu_t.size() - 1;
      chk(32'(dac_data), 32'(tx_word[15:2]));
      chk(32'(rx_word), 32'(adc_data));
      @(posedge clk);
      tx_word <= 16'h3c58;
      {fc_hi, fc_lo} <= 2'h0;
      while (pu_t.size() < p + 4) @(posedge clk);
      chk(gap(p), 32'(SP));
      chk(gap(p + 1), 32'(SP + int'(rows[i].delta)));
      chk(gap(p + 2), 32'(SP));
      nfs = 0;
      foreach (fall_t[j]) begin
        if (fall_t[j] > pu_t[p] && fall_t[j] < pu_t[p+1]) begin
          nfs++;
          if (nfs == 1) t1 = fall_t[j];
          else t2 = fall_t[j];
        end
      end
      chk(32'(nfs), 32'(1 + int'(rows[i].sec)));
      if (rows[i].sec) begin
        chk(32'((t2 - t1) > (SP * 2.0 - 16.0)), 32'h1);
        chk(32'((t2 - t1) < (SP * 2.0 + 16.0)), 32'h1);
        apb(1'b0, OFF_SEC, 32'h0, rd, er);
        chk(rd, 32'h3c58);
        apb(1'b0, OFF_STATUS, 32'h0, rd, er);
        chk(rd, 32'h1);
        apb(1'b1, OFF_STATUS, 32'h1, rd, er);
        apb(1'b0, OFF_STATUS, 32'h0, rd, er);
        chk(rd, 32'h0);
      end
    end
    // Reset in mid-run clears outputs and stops sampling
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(32'({frame_sync_n, dout_oe_n, pready, dac_valid, sample_pulse}),
        32'h18);
    @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0, rd, er);
    chk(rd, 32'h0);
    n0 = pu_t.size();
    // A frame cut by reset may still finish in the host; count after it
    repeat (SP) @(posedge clk);
    nfs = rx_cnt;
    repeat (SP) @(posedge clk);
    chk(32'(pu_t.size() - n0), 32'h0);
    chk(rx_cnt, 32'(nfs));
    give_verdict();
  end
endmodule
`default_nettype wire
